//--- pkg/qli_defs.svh
// Notes on behaviour
// - Offset zero reads a fixed 8-bit identity and revision value; writes do nothing.
// - Analog loopback bits enable loopback per channel when set; reset clears them.
// - Remote loopback bits switch each channel into remote loopback; reset clears them.
// - Digital loopback bits place each channel in digital loopback; reset clears them.
// - All-ones bits make each channel send continuous ones; reset clears them.
// - Signal-loss status shows each channel's current loss condition in bits three to zero.
// - Driver fault status shows each channel's current driver fault in bits three to zero.
// - Signal-loss mask bit one allows that channel's interrupt; reset blocks all.
// - Driver fault mask bit one allows that channel's interrupt; reset blocks all.
// - Loss flag sets on any loss status change while masked in; loss read clears it.
// - Fault flag sets on any fault status change while masked in; fault read clears it.
// - A write to reset register while no reset runs starts a one microsecond reset of all registers.
// - Monitor code picks receiver or transmitter one to three; 0000 and 1000 monitor nothing.
// - In E1 each criterion bit picks G.775 at zero or ETSI 300 233 at one.
// - In T1 loss and alarm detection follows T1.231 whatever the criterion bits say.
`ifndef QLI_DEFS_SVH
`define QLI_DEFS_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define QLI_OFS_ID       5'h00
`define QLI_OFS_ALOOP    5'h01
`define QLI_OFS_RLOOP    5'h02
`define QLI_OFS_ONES     5'h03
`define QLI_OFS_LOS_ST   5'h04
`define QLI_OFS_FLT_ST   5'h05
`define QLI_OFS_LOS_MSK  5'h06
`define QLI_OFS_FLT_MSK  5'h07
`define QLI_OFS_LOS_FLG  5'h08
`define QLI_OFS_FLT_FLG  5'h09
`define QLI_OFS_SWRST    5'h0a
`define QLI_OFS_MON      5'h0b
`define QLI_OFS_DLOOP    5'h0c
`define QLI_OFS_CRIT     5'h0d

// ---------------------------------------------------------------------------
// Reset values and read-back constants
// ---------------------------------------------------------------------------
`define QLI_CHAN_RST     4'h0
`define QLI_SWRST_READ   8'hff
`define QLI_UNMAPPED     8'h00
// The identity value is arbitrary; a real part fixes its own code at manufacture.
`define QLI_ID_DEFAULT   8'h5a

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define QLI_CLK_PERIOD_NS 50
`define QLI_SWRST_TIME_NS 1000
`define QLI_SWRST_CYCLES  ((`QLI_SWRST_TIME_NS + `QLI_CLK_PERIOD_NS - 1) / `QLI_CLK_PERIOD_NS)

`endif

//--- pkg/qli_pkg.sv
package qli_pkg;

  `include "qli_defs.svh"

  typedef logic [3:0] qli_chan_t;
  typedef logic [4:0] qli_addr_t;
  typedef logic [4:0] qli_cnt_t;

  typedef enum logic [3:0] {
    QLI_MON_OFF  = 4'h0,
    QLI_MON_RX1  = 4'h1,
    QLI_MON_RX2  = 4'h2,
    QLI_MON_RX3  = 4'h3,
    QLI_MON_OFF2 = 4'h8,
    QLI_MON_TX1  = 4'h9,
    QLI_MON_TX2  = 4'ha,
    QLI_MON_TX3  = 4'hb
  } qli_mon_code_t;

  typedef enum logic [0:0] {
    QLI_RST_IDLE = 1'b0,
    QLI_RST_BUSY = 1'b1
  } qli_rst_state_t;

  // True only for codes that actually route a monitor point.
  function automatic logic qli_mon_valid(input logic [3:0] code);
    return (code == QLI_MON_RX1) || (code == QLI_MON_RX2) || (code == QLI_MON_RX3) ||
           (code == QLI_MON_TX1) || (code == QLI_MON_TX2) || (code == QLI_MON_TX3);
  endfunction : qli_mon_valid

  // Per-channel registers keep four bits; the upper nibble reads as zero.
  function automatic logic [7:0] qli_nib(input logic [3:0] v);
    return {4'h0, v};
  endfunction : qli_nib

endpackage : qli_pkg

//--- core/qli_sync.sv
`timescale 1ns/1ps
module qli_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // Asynchronous input and its synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import qli_pkg::*;

  logic [W-1:0] s1_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      q    <= s1_q;
    end
  end

endmodule : qli_sync

//--- core/qli_chg_flags.sv
`timescale 1ns/1ps
`include "qli_defs.svh"
module qli_chg_flags (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              srst,
  // Status, mask and clear
  input  wire qli_pkg::qli_chan_t status,
  input  wire qli_pkg::qli_chan_t mask,
  input  wire logic              clr,
  // Latched change flags
  output qli_pkg::qli_chan_t     flags
);
  import qli_pkg::*;

  qli_chan_t prev_q;
  qli_chan_t flags_q;
  qli_chan_t flags_d;
  qli_chan_t set_w;

  // A change caught in the clearing cycle still sets, so no event is lost.
  assign set_w   = (status ^ prev_q) & mask;
  assign flags_d = srst ? `QLI_CHAN_RST : ((flags_q & ~{4{clr}}) | set_w);
  assign flags   = flags_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prev_q  <= `QLI_CHAN_RST;
      flags_q <= `QLI_CHAN_RST;
    end else begin
      prev_q  <= status;
      flags_q <= flags_d;
    end
  end

  flag_sets_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (!srst && ((status ^ prev_q) & mask) != 4'h0) |=> ((flags_q & $past(set_w)) == $past(set_w)))
    else $error("masked status change did not set its flag");

  flag_clears_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (clr && set_w == 4'h0) |=> flags_q == 4'h0)
    else $error("flag survived a status read without a new change");

endmodule : qli_chg_flags

//--- core/qli_regs.sv
`timescale 1ns/1ps
`include "qli_defs.svh"
module qli_regs #(
  parameter logic [7:0] ID_VALUE = `QLI_ID_DEFAULT
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Parallel host port
  input  wire logic              host_cs_n,
  input  wire logic              host_wr_n,
  input  wire logic              host_rd_n,
  input  wire qli_pkg::qli_addr_t host_addr,
  input  wire logic [7:0]        host_data_in,
  output logic [7:0]             host_data_out,
  output logic                   host_data_oe,
  // Line status from the channel logic
  input  wire qli_pkg::qli_chan_t los_in,
  input  wire qli_pkg::qli_chan_t drv_fault_in,
  input  wire logic              t1_mode,
  // Channel controls
  output qli_pkg::qli_chan_t     analog_loopback_en,
  output qli_pkg::qli_chan_t     remote_loopback_en,
  output qli_pkg::qli_chan_t     digital_loopback_en,
  output qli_pkg::qli_chan_t     all_ones_tx_en,
  output qli_pkg::qli_chan_t     los_criterion_etsi,
  output logic                   los_criterion_t1,
  // Monitor routing
  output logic                   monitor_enable,
  output logic                   monitor_transmit,
  output logic [1:0]             monitor_channel,
  // Soft reset in progress
  output logic                   sw_reset_busy
);
  import qli_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------
  // The host holds address and data steady around its strobes, so passing them
  // through the same two stages keeps them aligned with the strobe edges.
  logic [2:0]  strb_s;
  logic [12:0] bus_s;
  qli_chan_t   los_s;
  qli_chan_t   flt_s;
  logic        t1_s;

  qli_sync #(.W(3)) u_sync_strb (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       ({~host_cs_n, ~host_wr_n, ~host_rd_n}),
    .q       (strb_s)
  );

  qli_sync #(.W(13)) u_sync_bus (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       ({host_addr, host_data_in}),
    .q       (bus_s)
  );

  qli_sync #(.W(9)) u_sync_line (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       ({t1_mode, drv_fault_in, los_in}),
    .q       ({t1_s, flt_s, los_s})
  );

  // ---------------------------------------------------------------------------
  // Host strobe decode
  // ---------------------------------------------------------------------------
  qli_addr_t addr_s;
  logic [7:0] wdata_s;
  logic       wr_act;
  logic       rd_act;
  logic       wr_act_q;
  logic       rd_act_q;
  logic       wr_start;
  logic       rd_start;

  assign addr_s   = bus_s[12:8];
  assign wdata_s  = bus_s[7:0];
  assign wr_act   = strb_s[2] & strb_s[1];
  assign rd_act   = strb_s[2] & strb_s[0];
  assign wr_start = wr_act & ~wr_act_q;
  assign rd_start = rd_act & ~rd_act_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
    end
  end

  // ---------------------------------------------------------------------------
  // Software reset sequencer
  // ---------------------------------------------------------------------------
  // Writes arriving while the reset runs are dropped; the host has to wait for
  // the reset to end before reprogramming anything.
  qli_rst_state_t rst_state_q;
  qli_rst_state_t rst_state_d;
  qli_cnt_t       rst_cnt_q;
  qli_cnt_t       rst_cnt_d;
  logic           srst;
  logic           wr_ok;
  logic           swrst_hit;

  assign srst      = (rst_state_q == QLI_RST_BUSY);
  assign wr_ok     = wr_start & ~srst;
  assign swrst_hit = wr_ok & (addr_s == `QLI_OFS_SWRST);

  always_comb begin
    rst_state_d = rst_state_q;
    rst_cnt_d   = rst_cnt_q;
    unique case (rst_state_q)
      QLI_RST_IDLE: begin
        if (swrst_hit) begin
          rst_state_d = QLI_RST_BUSY;
          rst_cnt_d   = 5'(`QLI_SWRST_CYCLES - 1);
        end
      end
      QLI_RST_BUSY: begin
        if (rst_cnt_q == 5'h00) begin
          rst_state_d = QLI_RST_IDLE;
        end else begin
          rst_cnt_d = rst_cnt_q - 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_state_q <= QLI_RST_IDLE;
      rst_cnt_q   <= 5'h00;
    end else begin
      rst_state_q <= rst_state_d;
      rst_cnt_q   <= rst_cnt_d;
    end
  end

  assign sw_reset_busy = srst;

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  // Only the low nibble is stored; the upper bits are expected to be written as
  // zero and are simply not kept.
  qli_chan_t aloop_q, aloop_d;
  qli_chan_t rloop_q, rloop_d;
  qli_chan_t ones_q, ones_d;
  qli_chan_t lmask_q, lmask_d;
  qli_chan_t fmask_q, fmask_d;
  qli_chan_t mon_q, mon_d;
  qli_chan_t dloop_q, dloop_d;
  qli_chan_t csel_q, csel_d;
  qli_chan_t wnib;

  assign wnib    = wdata_s[3:0];
  assign aloop_d = srst ? `QLI_CHAN_RST : (wr_ok && addr_s == `QLI_OFS_ALOOP)   ? wnib : aloop_q;
  assign rloop_d = srst ? `QLI_CHAN_RST : (wr_ok && addr_s == `QLI_OFS_RLOOP)   ? wnib : rloop_q;
  assign ones_d  = srst ? `QLI_CHAN_RST : (wr_ok && addr_s == `QLI_OFS_ONES)    ? wnib : ones_q;
  assign lmask_d = srst ? `QLI_CHAN_RST : (wr_ok && addr_s == `QLI_OFS_LOS_MSK) ? wnib : lmask_q;
  assign fmask_d = srst ? `QLI_CHAN_RST : (wr_ok && addr_s == `QLI_OFS_FLT_MSK) ? wnib : fmask_q;
  assign mon_d   = srst ? `QLI_CHAN_RST : (wr_ok && addr_s == `QLI_OFS_MON)     ? wnib : mon_q;
  assign dloop_d = srst ? `QLI_CHAN_RST : (wr_ok && addr_s == `QLI_OFS_DLOOP)   ? wnib : dloop_q;
  assign csel_d  = srst ? `QLI_CHAN_RST : (wr_ok && addr_s == `QLI_OFS_CRIT)    ? wnib : csel_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aloop_q <= `QLI_CHAN_RST;
      rloop_q <= `QLI_CHAN_RST;
      ones_q  <= `QLI_CHAN_RST;
      lmask_q <= `QLI_CHAN_RST;
      fmask_q <= `QLI_CHAN_RST;
      mon_q   <= `QLI_CHAN_RST;
      dloop_q <= `QLI_CHAN_RST;
      csel_q  <= `QLI_CHAN_RST;
    end else begin
      aloop_q <= aloop_d;
      rloop_q <= rloop_d;
      ones_q  <= ones_d;
      lmask_q <= lmask_d;
      fmask_q <= fmask_d;
      mon_q   <= mon_d;
      dloop_q <= dloop_d;
      csel_q  <= csel_d;
    end
  end

  assign analog_loopback_en  = aloop_q;
  assign remote_loopback_en  = rloop_q;
  assign digital_loopback_en = dloop_q;
  assign all_ones_tx_en      = ones_q;

  // ---------------------------------------------------------------------------
  // Monitor routing and detection criterion
  // ---------------------------------------------------------------------------
  // Reserved monitor codes are treated as no monitoring, the safe fallback.
  logic       mon_en_d;
  logic       mon_en_q;
  logic       mon_tx_q;
  logic [1:0] mon_ch_q;
  qli_chan_t  crit_d;
  qli_chan_t  crit_q;
  logic       crit_t1_q;

  assign mon_en_d = qli_mon_valid(mon_d);
  assign crit_d   = t1_s ? `QLI_CHAN_RST : csel_d;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mon_en_q  <= 1'b0;
      mon_tx_q  <= 1'b0;
      mon_ch_q  <= 2'h0;
      crit_q    <= `QLI_CHAN_RST;
      crit_t1_q <= 1'b0;
    end else begin
      mon_en_q  <= mon_en_d;
      mon_tx_q  <= mon_en_d & mon_d[3];
      mon_ch_q  <= mon_en_d ? mon_d[1:0] : 2'h0;
      crit_q    <= crit_d;
      crit_t1_q <= t1_s;
    end
  end

  assign monitor_enable     = mon_en_q;
  assign monitor_transmit   = mon_tx_q;
  assign monitor_channel    = mon_ch_q;
  assign los_criterion_etsi = crit_q;
  assign los_criterion_t1   = crit_t1_q;

  // ---------------------------------------------------------------------------
  // Status change flags
  // ---------------------------------------------------------------------------
  // Flags clear at the start of a status read, the cycle in which the status
  // value is captured, so a change during the read strobe is still flagged.
  qli_chan_t los_flg;
  qli_chan_t flt_flg;
  logic      los_clr;
  logic      flt_clr;

  assign los_clr = rd_start & (addr_s == `QLI_OFS_LOS_ST);
  assign flt_clr = rd_start & (addr_s == `QLI_OFS_FLT_ST);

  qli_chg_flags u_los_flags (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .srst    (srst),
    .status  (los_s),
    .mask    (lmask_q),
    .clr     (los_clr),
    .flags   (los_flg)
  );

  qli_chg_flags u_flt_flags (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .srst    (srst),
    .status  (flt_s),
    .mask    (fmask_q),
    .clr     (flt_clr),
    .flags   (flt_flg)
  );

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  assign rd_mux =
    (addr_s == `QLI_OFS_ID)      ? ID_VALUE         :
    (addr_s == `QLI_OFS_ALOOP)   ? qli_nib(aloop_q) :
    (addr_s == `QLI_OFS_RLOOP)   ? qli_nib(rloop_q) :
    (addr_s == `QLI_OFS_ONES)    ? qli_nib(ones_q)  :
    (addr_s == `QLI_OFS_LOS_ST)  ? qli_nib(los_s)   :
    (addr_s == `QLI_OFS_FLT_ST)  ? qli_nib(flt_s)   :
    (addr_s == `QLI_OFS_LOS_MSK) ? qli_nib(lmask_q) :
    (addr_s == `QLI_OFS_FLT_MSK) ? qli_nib(fmask_q) :
    (addr_s == `QLI_OFS_LOS_FLG) ? qli_nib(los_flg) :
    (addr_s == `QLI_OFS_FLT_FLG) ? qli_nib(flt_flg) :
    (addr_s == `QLI_OFS_SWRST)   ? `QLI_SWRST_READ  :
    (addr_s == `QLI_OFS_MON)     ? qli_nib(mon_q)   :
    (addr_s == `QLI_OFS_DLOOP)   ? qli_nib(dloop_q) :
    (addr_s == `QLI_OFS_CRIT)    ? qli_nib(csel_q)  :
                                   `QLI_UNMAPPED;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (rd_start) begin
      rdata_q <= rd_mux;
    end
  end

  assign host_data_out = rdata_q;
  assign host_data_oe  = rd_act_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  id_readback_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd_start && addr_s == `QLI_OFS_ID) |=> (rdata_q == ID_VALUE))
    else $error("identity read returned a wrong value");

  aloop_write_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_ok && addr_s == `QLI_OFS_ALOOP) |=> (analog_loopback_en == $past(wdata_s[3:0])))
    else $error("analog loopback write not applied");

  rloop_hold_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (!srst && !(wr_ok && addr_s == `QLI_OFS_RLOOP)) |=> $stable(remote_loopback_en))
    else $error("remote loopback changed without a write");

  dloop_write_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_ok && addr_s == `QLI_OFS_DLOOP) |=> (digital_loopback_en == $past(wdata_s[3:0])))
    else $error("digital loopback write not applied");

  ones_write_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_ok && addr_s == `QLI_OFS_ONES) |=> (all_ones_tx_en == $past(wdata_s[3:0])))
    else $error("all-ones write not applied");

  los_readback_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd_start && addr_s == `QLI_OFS_LOS_ST) |=> (rdata_q == {4'h0, $past(los_s)}))
    else $error("loss status read wrong");

  flt_readback_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd_start && addr_s == `QLI_OFS_FLT_ST) |=> (rdata_q == {4'h0, $past(flt_s)}))
    else $error("driver fault status read wrong");

  los_masked_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (lmask_q == 4'h0 && los_flg == 4'h0) |=> (los_flg == 4'h0))
    else $error("loss flag set while fully masked");

  flt_masked_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (fmask_q == 4'h0 && flt_flg == 4'h0) |=> (flt_flg == 4'h0))
    else $error("fault flag set while fully masked");

  swrst_len_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    swrst_hit |-> ##1 srst [*8] ##12 srst ##1 !srst)
    else $error("soft reset length wrong");

  swrst_clear_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    swrst_hit |-> ##2 (aloop_q == 4'h0 && lmask_q == 4'h0 && mon_q == 4'h0 && csel_q == 4'h0))
    else $error("soft reset left a register set");

  mon_route_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    monitor_enable |-> (monitor_channel != 2'h0 && monitor_transmit == mon_q[3] && mon_q[2] == 1'b0))
    else $error("monitor routing inconsistent with code");

  t1_crit_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(t1_s) |-> (los_criterion_etsi == 4'h0 && los_criterion_t1))
    else $error("E1 criterion leaked into T1 mode");

  swrst_read_a : assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd_start && addr_s == `QLI_OFS_SWRST) |=> (rdata_q == 8'hff))
    else $error("reset register read wrong");

endmodule : qli_regs

//--- bench/qli_host_model.sv
`timescale 1ns/1ps
module qli_host_model (
  // Clock
  input  wire logic          ref_clk,
  // Host port pins
  output logic               cs_n,
  output logic               wr_n,
  output logic               rd_n,
  output qli_pkg::qli_addr_t addr,
  output logic [7:0]         dout,
  input  wire logic [7:0]    din,
  input  wire logic          oe
);
  import qli_pkg::*;

  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    addr = 5'h00;
    dout = 8'h00;
  end

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // Strobes stay low past the two sync stages and the register stage.
  // The gap after release lets the edge detector see a low sample.
  task automatic wr(input qli_addr_t a, input logic [7:0] d);
    addr = a;
    dout = d;
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    cs_n = 1'b1;
    wr_n = 1'b1;
    // A released data line must not keep looking valid.
    dout = ~d;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : wr

  task automatic rd(input qli_addr_t a, output logic [7:0] d);
    addr = a;
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    d = oe ? din : 8'hxx;
    #1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : rd
endmodule : qli_host_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import qli_pkg::*;

  typedef struct packed {
    qli_addr_t  a;
    logic [7:0] w;
    logic [7:0] e;
  } qli_row_t;

  // The identity value is arbitrary.
  localparam logic [7:0] ID = 8'h3c;

  logic       ref_clk, nrst, cs_n, wr_n, rd_n, oe, crit_t1, mon_en, mon_tx, busy, t1;
  logic [7:0] din, dout, rd_v;
  logic [1:0] mon_ch;
  qli_addr_t  addr;
  qli_chan_t  signal_loss_status, flt, aloop, rloop, dloop, ones, etsi;
  int         err_count = 0;
  int         total_checks = 0;
  int         busy_cnt = 0;
  int         cyc = 0;
  logic [3:0] mon_codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
  qli_row_t   rows [12] = '{
    '{5'h01, 8'h0a, 8'h0a},
    '{5'h02, 8'h05, 8'h05},
    '{5'h03, 8'h03, 8'h03},
    '{5'h06, 8'h0f, 8'h0f},
    '{5'h07, 8'h0f, 8'h0f},
    '{5'h0b, 8'h09, 8'h09},
    '{5'h0c, 8'h0c, 8'h0c},
    '{5'h0d, 8'h06, 8'h06},
    '{5'h00, 8'h33, ID},
    '{5'h04, 8'h0f, 8'h00},
    '{5'h08, 8'h0f, 8'h00},
    '{5'h1f, 8'h05, 8'h00}
  };

  qli_regs #(.ID_VALUE(ID)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .host_cs_n(cs_n), .host_wr_n(wr_n), .host_rd_n(rd_n),
    .host_addr(addr), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
    .los_in(signal_loss_status), .drv_fault_in(flt), .t1_mode(t1), .analog_loopback_en(aloop),
    .remote_loopback_en(rloop), .digital_loopback_en(dloop), .all_ones_tx_en(ones),
    .los_criterion_etsi(etsi), .los_criterion_t1(crit_t1), .monitor_enable(mon_en),
    .monitor_transmit(mon_tx), .monitor_channel(mon_ch), .sw_reset_busy(busy)
  );

  qli_host_model i_host (
    .ref_clk(ref_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
    .dout(din), .din(dout), .oe(oe)
  );

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t pins %h expected %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic rc(input qli_addr_t a, input logic [7:0] e);
    i_host.rd(a, rd_v);
    chk_rd(rd_v, e);
  endtask : rc

  // Status inputs pass two sync stages before the flag logic sees them.
  task automatic settle();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : settle

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (busy === 1'b1) busy_cnt++;
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    signal_loss_status = 4'h0;
    flt = 4'h0;
    t1 = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    foreach (rows[i]) begin
      i_host.wr(rows[i].a, rows[i].w);
      rc(rows[i].a, rows[i].e);
    end
    chk_pin({aloop, rloop}, 8'ha5);
    chk_pin({ones, dloop}, 8'h3c);
    foreach (mon_codes[i]) begin
      i_host.wr(5'h0b, {4'h0, mon_codes[i]});
      chk_pin({4'h0, mon_en, mon_tx, mon_ch}, (mon_codes[i][1:0] != 2'h0) ?
              {5'h01, mon_codes[i][3], mon_codes[i][1:0]} : 8'h00);
    end
    t1 = 1'b1;
    settle();
    chk_pin({crit_t1, etsi}, 8'h10);
    t1 = 1'b0;
    settle();
    chk_pin({crit_t1, etsi}, 8'h06);
    signal_loss_status = 4'h4;
    settle();
    rc(5'h08, 8'h04);
    rc(5'h04, 8'h04);
    rc(5'h08, 8'h00);
    signal_loss_status = 4'h0;
    settle();
    rc(5'h08, 8'h04);
    i_host.wr(5'h06, 8'h00);
    signal_loss_status = 4'h2;
    settle();
    rc(5'h04, 8'h02);
    rc(5'h08, 8'h00);
    flt = 4'h1;
    settle();
    rc(5'h09, 8'h01);
    rc(5'h05, 8'h01);
    rc(5'h09, 8'h00);
    i_host.wr(5'h07, 8'h00);
    flt = 4'h0;
    settle();
    rc(5'h09, 8'h00);
    i_host.wr(5'h0a, 8'h00);
    repeat (24) @(posedge ref_clk);
    #1;
    chk_pin(8'(busy_cnt), 8'h14);
    chk_pin({aloop, ones}, 8'h00);
    rc(5'h0d, 8'h00);
    rc(5'h0a, 8'hff);
    i_host.wr(5'h01, 8'h0f);
    nrst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_pin({aloop, rloop}, 8'h00);
    nrst = 1'b1;
    rc(5'h01, 8'h00);
    rc(5'h0b, 8'h00);
    complete_run();
  end
endmodule : tb_top
